// *** rtl/status_check_pkg.sv ***
// Constants and types for the LE-side status enquiry and state check block.
// Assumes a single 125 MHz clock domain.
`default_nettype none
package status_check_pkg;
   // (R06) LE state codes
   localparam logic [2:0] LE_OOS = 3'h0;
   localparam logic [2:0] LE_NULL = 3'h1;
   localparam logic [2:0] LE_INIT_LE = 3'h2;
   localparam logic [2:0] LE_INIT_AN = 3'h3;
   localparam logic [2:0] LE_ACTIVE = 3'h4;
   localparam logic [2:0] LE_DISC_REQ = 3'h5;
   localparam logic [2:0] LE_BLOCKED = 3'h6;
   // (R07) AN state codes
   localparam logic [2:0] AN_OOS = 3'h0;
   localparam logic [2:0] AN_NULL = 3'h1;
   localparam logic [2:0] AN_INIT_AN = 3'h2;
   localparam logic [2:0] AN_ABORT = 3'h3;
   localparam logic [2:0] AN_LINE_INFO = 3'h4;
   localparam logic [2:0] AN_ACTIVE = 3'h5;
   localparam logic [2:0] AN_BLOCKED = 3'h6;
   localparam logic [2:0] AN_DISC_REQ = 3'h7;
   // Outcome of the compatibility lookup
   localparam logic [1:0] MAP_OK = 2'h0;
   localparam logic [1:0] MAP_PENDING = 2'h1;
   localparam logic [1:0] MAP_DISC = 2'h2;
   localparam logic [1:0] MAP_ERROR = 2'h3;
   // Supervision timer T4 default
   localparam int T4_MS = 1;
   localparam int CLK_MHZ = 125;
   localparam int T4_CYCLES = T4_MS * CLK_MHZ * 1000;
   localparam logic [1:0] EXPIRY_LIMIT = 2'h3;
   localparam logic [1:0] EXPIRY_RESET = 2'h0;

   typedef enum logic [1:0] {
      IDLE = 2'b01,
      WAIT_REPLY = 2'b10
   } enq_state_e;

   // Compatibility map between LE state and reported AN state
   function automatic logic [1:0] state_map(input logic [2:0] le, input logic [2:0] an);
      logic [1:0] r;
      r = MAP_ERROR;
      if (an == AN_OOS) begin
         r = (le == LE_OOS) ? MAP_OK : MAP_ERROR;
      end else if (an == AN_BLOCKED) begin
         r = (le == LE_BLOCKED) ? MAP_OK : MAP_ERROR;
      end else if (le == LE_OOS || le == LE_BLOCKED || le == 3'h7) begin
         r = MAP_ERROR;
      end else if (le == LE_DISC_REQ || an == AN_DISC_REQ) begin
         r = MAP_PENDING;
      end else begin
         unique case (an)
            AN_NULL: r = (le <= LE_INIT_LE) ? MAP_OK : MAP_DISC;
            AN_INIT_AN: r = (le <= LE_INIT_AN) ? MAP_OK : MAP_DISC;
            AN_ABORT, AN_LINE_INFO:
               r = (le == LE_NULL || le == LE_INIT_AN) ? MAP_OK : MAP_DISC;
            AN_ACTIVE: r = (le == LE_ACTIVE) ? MAP_OK : MAP_DISC;
            default: r = MAP_ERROR;
         endcase
      end
      return r;
   endfunction
endpackage
`default_nettype wire

// *** rtl/status_enquiry_state_check.sv ***
// LE-side status enquiry with T4 supervision and LE/AN state compatibility check.
// Assumes message decode/encode logic on the same clock; trigger and STATUS receive inputs are one-cycle pulses.
//
// What this block does and expects of AN
// (R01) Only LE starts enquiry: request or unexpected
// (R02) Unexpected message discarded, STATUS ENQUIRY sent
// (R03) T4 starts when enquiry sent
// (R04) AN answers enquiry with STATUS and cause
// (R05) STATUS reply stops T4, map lookup
// (R06) LE states coded LE0 to LE6
// (R07) AN states coded AN0 to AN7
// (R08) Compatible pairs: report, keep state
// (R09) Disconnect-pending pairs: no action, keep state
// (R10) Sync pairs: DISCONNECT, enter LE5
// (R11) Other pairs: error to management, keep state
// (R12) First, second T4 expiry: resend, restart
// (R13) Third expiry, not blocked/OOS: DISCONNECT, error
// (R14) Third expiry, blocked/OOS: error only
// (R15) Only AN starts status procedure
// (R16) Unsolicited STATUS compatible: internal error only; block ignores it in LE5
// (R17) Unsolicited STATUS incompatible: error, DISCONNECT; block ignores it in LE5
// (R18) Expiry counter clears on start, reply
`timescale 1ns/1ps
`default_nettype none
module status_enquiry_state_check
   import status_check_pkg::*;
#(
   parameter int T4_COUNT = status_check_pkg::T4_CYCLES
) (
   // Clock, reset, enable
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // Current LE path state
   input wire logic [2:0] le_state_i,
   // Triggers
   input wire logic enquiry_req_i,
   input wire logic unexpected_msg_i,
   // Received STATUS
   input wire logic status_rx_i,
   input wire logic status_is_reply_i,
   input wire logic [2:0] an_state_i,
   // Transmit requests
   output logic send_enquiry_o,
   output logic send_disconnect_o,
   // Indications
   output logic goto_disc_req_o,
   output logic report_ok_o,
   output logic mgmt_error_o,
   output logic internal_error_o,
   output logic busy_o
);
   import status_check_pkg::*;

   localparam int TW = $clog2(T4_COUNT + 1);

   enq_state_e state, next_state;
   logic [TW-1:0] timer, next_timer;
   logic [1:0] expiry, next_expiry;
   logic next_send_enquiry, next_send_disconnect, next_goto_disc;
   logic next_report_ok, next_mgmt_error, next_internal_error;
   logic next_busy;
   logic [1:0] verdict;
   logic start, timeout, reply, unsol;

   always_comb begin
      verdict = state_map(le_state_i, an_state_i);
      // (R01) LE-only enquiry start
      start = enquiry_req_i || unexpected_msg_i;
      timeout = (state == WAIT_REPLY) && (timer == TW'(1));
      reply = (state == WAIT_REPLY) && status_rx_i && status_is_reply_i;
      unsol = status_rx_i && !status_is_reply_i && (le_state_i != LE_DISC_REQ);
      next_state = state;
      next_timer = (state == WAIT_REPLY && timer != '0) ? timer - TW'(1) : timer;
      next_expiry = expiry;
      next_send_enquiry = 1'b0;
      next_send_disconnect = 1'b0;
      next_goto_disc = 1'b0;
      next_report_ok = 1'b0;
      next_mgmt_error = 1'b0;
      next_internal_error = 1'b0;
      if (reply) begin
         // (R05) Stop T4, look up map
         next_state = IDLE;
         next_timer = '0;
         // (R18) Clear on accepted reply
         next_expiry = EXPIRY_RESET;
         unique case (verdict)
            // (R08) Compatible report
            MAP_OK: next_report_ok = 1'b1;
            // (R09) Disconnect pending, nothing
            MAP_PENDING: next_report_ok = 1'b0;
            // (R10) Disconnect and enter LE5
            MAP_DISC: begin
               next_send_disconnect = 1'b1;
               next_goto_disc = 1'b1;
            end
            // (R11) Error to management
            default: next_mgmt_error = 1'b1;
         endcase
      end else if (start) begin
         // (R02) Discard message, send enquiry
         next_send_enquiry = 1'b1;
         // (R03) Start T4 with the enquiry
         next_timer = TW'(T4_COUNT);
         next_state = WAIT_REPLY;
         // (R18) Clear on new enquiry
         next_expiry = EXPIRY_RESET;
      end else if (timeout) begin
         next_expiry = expiry + 2'h1;
         if (expiry + 2'h1 < EXPIRY_LIMIT) begin
            // (R12) Resend and restart T4
            next_send_enquiry = 1'b1;
            next_timer = TW'(T4_COUNT);
         end else begin
            next_state = IDLE;
            next_internal_error = 1'b1;
            // (R13) Disconnect unless blocked/OOS
            // (R14) Blocked/OOS: error only
            if (le_state_i != LE_BLOCKED && le_state_i != LE_OOS) begin
               next_send_disconnect = 1'b1;
            end
         end
      end
      if (unsol) begin
         // (R16) Unsolicited STATUS raises error
         next_internal_error = 1'b1;
         // (R17) Incompatible: send DISCONNECT
         if (verdict == MAP_DISC || verdict == MAP_ERROR) begin
            next_send_disconnect = 1'b1;
            next_goto_disc = 1'b1;
         end
      end
      next_busy = (next_state == WAIT_REPLY);
   end

   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         state <= IDLE;
         timer <= '0;
         expiry <= EXPIRY_RESET;
         send_enquiry_o <= 1'b0;
         send_disconnect_o <= 1'b0;
         goto_disc_req_o <= 1'b0;
         report_ok_o <= 1'b0;
         mgmt_error_o <= 1'b0;
         internal_error_o <= 1'b0;
         busy_o <= 1'b0;
      end else if (ce_i) begin
         state <= next_state;
         timer <= next_timer;
         expiry <= next_expiry;
         send_enquiry_o <= next_send_enquiry;
         send_disconnect_o <= next_send_disconnect;
         goto_disc_req_o <= next_goto_disc;
         report_ok_o <= next_report_ok;
         mgmt_error_o <= next_mgmt_error;
         internal_error_o <= next_internal_error;
         busy_o <= next_busy;
      end
   end

   // Assertions; ce_i held high is assumed for cycle-exact checks
   a_enq_starts_timer: assert property (@(posedge clk_i) disable iff (!nrst_i) // R03
      send_enquiry_o |-> busy_o) else $error("enquiry sent without T4 running");
   a_start_sends_enq: assert property (@(posedge clk_i) disable iff (!nrst_i) // R02
      (ce_i && start && !reply) |=> send_enquiry_o) else $error("start without enquiry");
   a_reply_stops: assert property (@(posedge clk_i) disable iff (!nrst_i) // R05
      (ce_i && reply && !start) |=> !busy_o) else $error("T4 not stopped on reply");
   a_ok_report: assert property (@(posedge clk_i) disable iff (!nrst_i) // R08
      (ce_i && reply && verdict == MAP_OK) |=> report_ok_o && !send_disconnect_o)
      else $error("compatible pair not reported");
   a_pending_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i) // R09
      (ce_i && reply && !unsol && verdict == MAP_PENDING) |=>
      !send_disconnect_o && !mgmt_error_o && !report_ok_o)
      else $error("pending pair caused action");
   a_sync_disc: assert property (@(posedge clk_i) disable iff (!nrst_i) // R10
      (ce_i && reply && verdict == MAP_DISC) |=> send_disconnect_o && goto_disc_req_o)
      else $error("sync pair without disconnect");
   a_mgmt_err: assert property (@(posedge clk_i) disable iff (!nrst_i) // R11
      (ce_i && reply && verdict == MAP_ERROR) |=> mgmt_error_o)
      else $error("error pair not flagged");
   a_retry_resend: assert property (@(posedge clk_i) disable iff (!nrst_i) // R12
      (ce_i && timeout && !reply && !start && expiry < 2'h2) |=> send_enquiry_o && busy_o)
      else $error("expiry did not resend");
   a_third_disc: assert property (@(posedge clk_i) disable iff (!nrst_i) // R13
      (ce_i && timeout && !reply && !start && expiry == 2'h2
       && le_state_i != LE_BLOCKED && le_state_i != LE_OOS)
      |=> send_disconnect_o && internal_error_o && !busy_o)
      else $error("third expiry without disconnect");
   a_third_quiet: assert property (@(posedge clk_i) disable iff (!nrst_i) // R14
      (ce_i && timeout && !reply && !start && !unsol && expiry == 2'h2
       && (le_state_i == LE_BLOCKED || le_state_i == LE_OOS))
      |=> internal_error_o && !send_disconnect_o && !send_enquiry_o)
      else $error("third expiry in blocked sent a message");
   a_unsol_err: assert property (@(posedge clk_i) disable iff (!nrst_i) // R16
      (ce_i && unsol) |=> internal_error_o) else $error("unsolicited status not flagged");
   a_unsol_disc: assert property (@(posedge clk_i) disable iff (!nrst_i) // R17
      (ce_i && unsol && verdict[1]) |=> send_disconnect_o)
      else $error("incompatible unsolicited status without disconnect");
   a_counter_clear: assert property (@(posedge clk_i) disable iff (!nrst_i) // R18
      (ce_i && start && !reply) |=> expiry == EXPIRY_RESET)
      else $error("expiry counter not cleared");

   // An expiry that neither a reply nor a new start preempts
   sequence s_plain_expiry;
      ce_i && timeout && !reply && !start;
   endsequence
   // Every output low: the event left no trace
   sequence s_idle_quiet;
      !send_enquiry_o && !send_disconnect_o && !goto_disc_req_o && !report_ok_o
      && !mgmt_error_o && !internal_error_o && !busy_o;
   endsequence
   a_enq_origin: assert property (@(posedge clk_i) disable iff (!nrst_i) // R01
      (ce_i && !start && !timeout) |=> !send_enquiry_o)
      else $error("enquiry sent without request or expiry");
   a_expiry_count: assert property (@(posedge clk_i) disable iff (!nrst_i) // R18
      s_plain_expiry |=> expiry == $past(expiry) + 2'h1)
      else $error("expiry counter did not step");
   // A reply cause with no enquiry outstanding is dropped
   a_stray_reply: assert property (@(posedge clk_i) disable iff (!nrst_i) // R05
      (ce_i && status_rx_i && status_is_reply_i && state == IDLE && !start) |=> s_idle_quiet)
      else $error("reply accepted with no enquiry outstanding");
   a_unsol_in_disc: assert property (@(posedge clk_i) disable iff (!nrst_i) // R16
      (ce_i && status_rx_i && !status_is_reply_i && le_state_i == LE_DISC_REQ
       && state == IDLE && !start) |=> s_idle_quiet)
      else $error("unsolicited status acted on in disconnect request");
endmodule
`default_nettype wire

// *** sim/an_partner.sv ***
// Behavioural far end: answers the latest enquiry after a set delay, or not at all.
// Assumes the requests it watches are registered pulses on clk_i.
`timescale 1ns/1ps
`default_nettype none
module an_partner (
   // Clock and reset
   input wire logic clk_i,
   input wire logic nrst_i,
   // Control from the bench
   input wire logic enquiry_i,
   input wire logic unsol_i,
   input wire logic mute_i,
   input wire logic [2:0] state_i,
   input wire logic [4:0] delay_i,
   // STATUS towards the block
   output logic status_rx_o,
   output logic status_is_reply_o,
   output logic [2:0] an_state_o
);
   int cnt;
   always_ff @(posedge clk_i) begin
      // Idle lines wander so stale values never look valid
      status_rx_o <= 1'b0;
      status_is_reply_o <= ~status_is_reply_o;
      an_state_o <= ~an_state_o;
      if (!nrst_i) begin
         status_is_reply_o <= 1'b0;
         an_state_o <= '0;
         cnt <= -1;
      end else if (enquiry_i && !mute_i) begin
         cnt <= int'(delay_i);
      end else if (cnt > 0) begin
         cnt <= cnt - 1;
      end else if (cnt == 0) begin
         status_rx_o <= 1'b1;
         status_is_reply_o <= 1'b1;
         an_state_o <= state_i;
         cnt <= -1;
      end else if (unsol_i) begin
         status_rx_o <= 1'b1;
         status_is_reply_o <= 1'b0;
         an_state_o <= state_i;
      end
   end
endmodule
`default_nettype wire

// *** sim/testbench.sv ***
// Self-checking bench: table-driven model of the state check against the block.
// Assumes the far end model answers only when enquired or told to.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) check_count++; if ((a) !== (b)) begin failures++; \
   $display("ERROR t=%0t got %0h exp %0h", $time, a, b); end
module testbench;
   import status_check_pkg::*;
   localparam int T4 = 20;
   logic clk_i = 0, nrst_i = 0, ce_i = 1, enquiry_req_i = 0, unexpected_msg_i = 0;
   logic [2:0] le_state_i = 0, an_st = 0;
   logic status_rx_i, status_is_reply_i, mute = 0, unsol = 0;
   logic [2:0] an_state_i;
   logic [4:0] dly = 2;
   logic send_enquiry_o, send_disconnect_o, goto_disc_req_o, report_ok_o;
   logic mgmt_error_o, internal_error_o, busy_o;
   int failures = 0, check_count = 0, n_enq, n_dis, n_gd, n_ok, n_mg, n_ie;
   bit [31:0] seed = 32'hBAB5;
   byte c;
   // Rows are AN0..AN7, columns LE0..LE6
   string map [8] = '{"+******", "*++--/*", "*+++-/*", "*+-+-/*", "*+-+-/*", "*---+/*",
      "******+", "*/////*"};
   status_enquiry_state_check #(.T4_COUNT(T4)) dut (.clk_i(clk_i), .nrst_i(nrst_i),
      .ce_i(ce_i), .le_state_i(le_state_i), .enquiry_req_i(enquiry_req_i),
      .unexpected_msg_i(unexpected_msg_i), .status_rx_i(status_rx_i),
      .status_is_reply_i(status_is_reply_i), .an_state_i(an_state_i),
      .send_enquiry_o(send_enquiry_o), .send_disconnect_o(send_disconnect_o),
      .goto_disc_req_o(goto_disc_req_o), .report_ok_o(report_ok_o),
      .mgmt_error_o(mgmt_error_o), .internal_error_o(internal_error_o), .busy_o(busy_o));
   an_partner far_end (.clk_i(clk_i), .nrst_i(nrst_i), .enquiry_i(send_enquiry_o),
      .unsol_i(unsol), .mute_i(mute), .state_i(an_st), .delay_i(dly),
      .status_rx_o(status_rx_i), .status_is_reply_o(status_is_reply_i),
      .an_state_o(an_state_i));
   always #4 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      n_enq += int'(send_enquiry_o === 1'b1);
      n_dis += int'(send_disconnect_o === 1'b1);
      n_gd += int'(goto_disc_req_o === 1'b1);
      n_ok += int'(report_ok_o === 1'b1);
      n_mg += int'(mgmt_error_o === 1'b1);
      n_ie += int'(internal_error_o === 1'b1);
   end
   function automatic bit [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic step(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      step(1);
      s = 1'b0;
   endtask
   task automatic expect_all(input int e, d, g, o, m, i);
      `CHK(n_enq, e)
      `CHK(n_dis, d)
      if (g >= 0) begin
         `CHK(n_gd, g)
      end
      `CHK(n_ok, o)
      `CHK(n_mg, m)
      `CHK(n_ie, i)
      `CHK(busy_o, 1'b0)
      {n_enq, n_dis, n_gd, n_ok, n_mg, n_ie} = '0;
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      #(20000 * 8);
      failures++;
      give_verdict();
   end
   initial begin
      step(20);
      nrst_i = 1'b1;
      step(1);
      {n_enq, n_dis, n_gd, n_ok, n_mg, n_ie} = '0;
      for (int le = 0; le < 7; le++) begin
         for (int an = 0; an < 8; an++) begin
            le_state_i = 3'(le);
            an_st = 3'(an);
            dly = 5'(2 + rnd() % 12);
            if (an % 2 == 1) pulse(unexpected_msg_i);
            else pulse(enquiry_req_i);
            step(T4);
            c = map[an][le];
            expect_all(1, c == "-", c == "-", c == "+", c == "*", 0);
         end
      end
      $display("test reply map done");
      an_st = AN_NULL;
      dly = 5'h1F;
      for (int k = 0; k < 6; k++) begin
         le_state_i = (k == 0) ? LE_OOS : (k == 1) ? LE_BLOCKED : LE_ACTIVE;
         // Pass 5 lets the far end answer only after the third expiry
         mute = (k != 5);
         pulse(enquiry_req_i);
         `CHK(busy_o, 1'b1)
         if (k == 3) begin
            step(2 * T4 + 5);
            pulse(enquiry_req_i);
         end
         if (k == 4) begin
            step(5);
            ce_i = 1'b0;
            step(10);
            ce_i = 1'b1;
            step(2 * T4 + 10);
            `CHK(busy_o, 1'b1)
         end
         step(3 * T4 + 15);
         expect_all(k == 3 ? 6 : 3, k > 1, 0, 0, 0, 1);
      end
      mute = 1'b0;
      $display("test timeout done");
      repeat (60) begin
         le_state_i = 3'(rnd() % 7);
         an_st = 3'(rnd() % 8);
         pulse(unsol);
         step(5);
         c = map[an_st][le_state_i];
         if (le_state_i == LE_DISC_REQ) expect_all(0, 0, 0, 0, 0, 0);
         else expect_all(0, c == "-" || c == "*", c == "-" || c == "*", 0, 0, 1);
      end
      $display("test unsolicited done");
      give_verdict();
   end
endmodule
`default_nettype wire
